// File: ih_bus_master.sv
// fieldbus master model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module ih_bus_master (
  input  wire logic clk,
  output var logic [15:0] reg_addr,
  output var logic reg_rd,
  output var logic reg_wr,
  output var logic [15:0] reg_wdata
);
  initial begin
    reg_addr = 16'h0000;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end
  // launch at a falling edge, hold across one rising edge
  task automatic op(input logic w, input logic [15:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk);
  endtask
  // release, scrambling the lines so stale values are not mistaken for held ones
  task automatic idle(input int n);
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    repeat (n) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// File: ih_image_regs.vh
// register references, field positions and codes for the island head unit image
`ifndef IH_IMAGE_REGS_VH
`define IH_IMAGE_REGS_VH

// register references as seen on the register port
`define IH_OUT_FIRST    16'h9c41
`define IH_OUT_LAST     16'hac40
`define IH_DIAG_FIRST   16'hb12d
`define IH_DIAG_LAST    16'hb14f
`define IH_COMM_REG     16'hb12d
`define IH_GERR_REG     16'hb12e
`define IH_IN_FIRST     16'hb150
`define IH_IN_LAST      16'hc14f

// image geometry
`define IH_IMG_WORDS    4096
`define IH_IDX_W        12
`define IH_ECHO_PAIRS   32
`define IH_ECHO_LAST    5'h1f

// communication status, low byte state codes
`define IH_ST_INIT      8'h01
`define IH_ST_LAST      8'h0f
`define IH_ST_LO        7:0

// communication status, high byte error bits
`define IH_CB_LPRX      8
`define IH_CB_UNIT      9
`define IH_CB_BUSOFF    10
`define IH_CB_WARN      11
`define IH_CB_ERRCLR    12
`define IH_CB_LPTX      13
`define IH_CB_HPRX      14
`define IH_CB_HPTX      15
`define IH_COMM_FATAL   8'heb

// global error flags, bit 0 upward
`define IH_GE_FATAL     0
`define IH_GE_NFLAGS    13
`define IH_GE_ZERO      3'h0

// error counter warning level
`define IH_ERR_WARN     8'h60

// module types and their input block footprints
`define IH_TY_DI        2'h0
`define IH_TY_AI        2'h1
`define IH_TY_DO        2'h2
`define IH_TY_AO        2'h3
`define IH_N_DI         3'h2
`define IH_N_AI         3'h4
`define IH_N_DO         3'h1
`define IH_N_AO         3'h2

`endif

// File: ih_image_regs_sva.sv
// port assertions for the island head unit image and diagnostic registers
`timescale 1ns/1ps
`default_nettype none
module ih_image_regs_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_hit,
  input wire logic isl_in_we,
  input wire logic [1:0] isl_in_type,
  input wire logic [1:0] isl_in_sub,
  input wire logic isl_in_reject,
  input wire logic isl_ev_lprx_ovr,
  input wire logic isl_ev_hptx_ovr,
  input wire logic [7:0] isl_err_count,
  input wire logic isl_err_status,
  input wire logic isl_comm_halt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // read answers
  property p_rv; reg_rd |=> reg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_unm; reg_rd && !reg_hit |=> reg_rdata == 16'h0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_hit;
    reg_hit == ((reg_addr >= 16'h9c41 && reg_addr <= 16'hac40) || (reg_addr >= 16'hb12d && reg_addr <= 16'hc14f));
  endproperty
  a_hit: assert property (p_hit) else $error("address decode wrong");
  property p_code; reg_rd && reg_addr == 16'hb12d |=> reg_rdata[7:0] inside {[8'h01:8'h0f]}; endproperty
  a_code: assert property (p_code) else $error("state code out of range");
  property p_ghi; reg_rd && reg_addr == 16'hb12e |=> reg_rdata[15:13] == 3'h0; endproperty
  a_ghi: assert property (p_ghi) else $error("unused global bits set");
  // fatal conditions raise and hold the halt
  property p_fat; isl_ev_lprx_ovr || isl_ev_hptx_ovr |-> ##[1:2] isl_comm_halt; endproperty
  a_fat: assert property (p_fat) else $error("overrun did not halt");
  property p_warn; isl_err_status && isl_err_count >= 8'h60 |-> ##[1:2] isl_comm_halt; endproperty
  a_warn: assert property (p_warn) else $error("warning level did not halt");
  property p_hold; isl_comm_halt |=> isl_comm_halt; endproperty
  a_hold: assert property (p_hold) else $error("halt dropped");
  property p_rej;
    isl_in_we && (isl_comm_halt || (isl_in_type != 2'h1 && isl_in_sub >= 2'h2)) |-> isl_in_reject;
  endproperty
  a_rej: assert property (p_rej) else $error("entry not refused");
  c_comm: cover property (reg_rd && reg_addr == 16'hb12d);
  c_halt: cover property ($rose(isl_comm_halt));
  c_rej: cover property (isl_in_we && isl_in_reject);
endmodule
bind ih_image_regs_top ih_image_regs_sva u_sva (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
  .isl_in_we(isl_in_we), .isl_in_type(isl_in_type), .isl_in_sub(isl_in_sub),
  .isl_in_reject(isl_in_reject), .isl_ev_lprx_ovr(isl_ev_lprx_ovr), .isl_ev_hptx_ovr(isl_ev_hptx_ovr),
  .isl_err_count(isl_err_count), .isl_err_status(isl_err_status), .isl_comm_halt(isl_comm_halt));
`default_nettype wire

// File: ih_image_regs_top.v
// process image and diagnostic register bank of the island head unit
`timescale 1ns/1ps
`default_nettype none
`include "ih_image_regs.vh"

// Function
// - output image words readable and writable
// - output reads reflect fresh data immediately
// - input image at 45392 through 49487
// - digital input: data word, then status
// - analog input: four words, data/status
// - digital output echo kept current, reflex too
// - analog output: two status words only
// - diagnostic range 45357 to 45391 reserved
// - comm low byte holds one of fifteen codes
// - start-up states each get a code
// - running states each get a code
// - mismatch states each get a code
// - bit 8 low-priority receive overrun, fatal
// - bit 9 unit overrun, fatal
// - bit 10 island bus-off
// - bit 11 warning-level fatal, bit 12 cleared
// - bits 13-15 other queue overruns, fatal
// - one sticky global bit per error
// - fatal flag halts island communication
// - global flags cover twelve error kinds
// - all registers sixteen bits wide
module ih_image_regs_top (
  input  wire        clk,
  input  wire        rst_n,
  // register port
  input  wire [15:0] reg_addr,
  input  wire        reg_rd,
  input  wire        reg_wr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output reg         reg_rvalid,
  output wire        reg_hit,

  // input block entries from island modules
  input  wire        isl_in_we,
  input  wire [1:0]  isl_in_type,
  input  wire [11:0] isl_in_base,
  input  wire [1:0]  isl_in_sub,
  input  wire [15:0] isl_in_data,
  output wire        isl_in_reject,

  // reflex action writes into the output image
  input  wire        isl_reflex_we,
  input  wire [11:0] isl_reflex_idx,
  input  wire [15:0] isl_reflex_data,

  // communication state and error events
  input  wire [3:0]  isl_state,
  input  wire        isl_ev_lprx_ovr,
  input  wire        isl_ev_unit_ovr,
  input  wire        isl_ev_bus_off,
  input  wire        isl_ev_lptx_ovr,
  input  wire        isl_ev_hprx_ovr,
  input  wire        isl_ev_hptx_ovr,
  input  wire [7:0]  isl_err_count,
  input  wire        isl_err_status,
  input  wire [12:1] isl_gerr_evt,
  output wire        isl_comm_halt
);
  // reset release through two flops: assertion stays asynchronous,
  // release lands two edges later on a clean clock edge
  reg rst_s1_r;
  reg rst_s2_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rstn_i = rst_s2_r;

  // image memories, sixteen bits a word
  // neither is reset: a word reads unknown until first written
  reg [15:0] out_mem [0:`IH_IMG_WORDS-1];
  reg [15:0] in_mem  [0:`IH_IMG_WORDS-1];

  // echo pairs: output index bound to an input slot
  // the source index is matched against every output image write
  reg [11:0] echo_src_r [0:`IH_ECHO_PAIRS-1];
  reg [11:0] echo_dst_r [0:`IH_ECHO_PAIRS-1];
  reg        echo_vld_r [0:`IH_ECHO_PAIRS-1];
  reg [4:0]  echo_cnt_r;

  // diagnostic registers
  // low byte state code, high byte error bits, thirteen global flags
  reg [7:0]  state_code_r;
  reg [15:8] comm_err_r;
  reg [12:0] gerr_r;
  reg        err_status_d_r;
  reg        init_seen_r;

  // address decode; each image is a run of consecutive reference numbers
  wire in_out_rng  = (reg_addr >= `IH_OUT_FIRST) &&
                     (reg_addr <= `IH_OUT_LAST);
  wire in_in_rng   = (reg_addr >= `IH_IN_FIRST) &&
                     (reg_addr <= `IH_IN_LAST);
  wire in_diag_rng = (reg_addr >= `IH_DIAG_FIRST) &&
                     (reg_addr <= `IH_DIAG_LAST);
  // word offsets; only the low twelve bits index a 4096-word image
  wire [15:0] out_off = reg_addr - `IH_OUT_FIRST;
  wire [15:0] in_off  = reg_addr - `IH_IN_FIRST;
  wire [11:0] out_idx = out_off[11:0];
  wire [11:0] in_idx  = in_off[11:0];
  // the diagnostic range is claimed whole, unused words read zero
  assign reg_hit = in_out_rng ||
                   in_in_rng ||
                   in_diag_rng;

  // bus write into the output image, read/write capable
  // writes anywhere else are dropped without an indication
  wire bus_out_we = reg_wr && in_out_rng;

  // island entry mapping to its slot
  // the slot is the module's base plus the sub-slot inside its span
  wire [11:0] slot_idx;
  wire        slot_ok;
  ih_slot_map u_slot (
    .mod_type (isl_in_type),
    .mod_base (isl_in_base),
    .mod_sub  (isl_in_sub),
    .slot_idx (slot_idx),
    .slot_ok  (slot_ok)
  );

  // fatal indication halts the island side
  wire fatal_w = gerr_r[`IH_GE_FATAL];
  assign isl_comm_halt = fatal_w;
  // reflex writes stop with the halt; bus writes still reach the output image
  wire reflex_ok = isl_reflex_we && !fatal_w;

  // digital output entries bind an echo; data[11:0] is the output index
  wire is_echo_bind = (isl_in_type == `IH_TY_DO);
  // the fill counter saturates on the last slot; once that slot is valid
  // further bindings are refused rather than overwriting a live pair
  wire echo_full    = (echo_cnt_r == `IH_ECHO_LAST) &&
                      echo_vld_r[`IH_ECHO_PAIRS-1];
  // an entry lands only inside its module's span and while not halted
  wire in_accept    = isl_in_we &&
                      slot_ok &&
                      !fatal_w &&
                      !(is_echo_bind && echo_full);
  assign isl_in_reject = isl_in_we && !in_accept;

  // output image writes: bus then reflex, reflex wins a tie
  // so a reflex update on the same word is never lost
  always @(posedge clk) begin
    if (bus_out_we) begin
      out_mem[out_idx] <= reg_wdata;
    end
    if (reflex_ok) begin
      out_mem[isl_reflex_idx] <= isl_reflex_data;
    end
  end

  // echo table fill, one pair per accepted digital output entry;
  // pairs stay bound until reset
  integer k;
  always @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      echo_cnt_r <= 5'h00;
      for (k = 0; k < `IH_ECHO_PAIRS; k = k + 1) begin
        echo_vld_r[k] <= 1'b0;
        echo_src_r[k] <= 12'h000;
        echo_dst_r[k] <= 12'h000;
      end
    end else if (in_accept && is_echo_bind) begin
      echo_src_r[echo_cnt_r] <= isl_in_data[11:0];
      echo_dst_r[echo_cnt_r] <= slot_idx;
      echo_vld_r[echo_cnt_r] <= 1'b1;
      if (echo_cnt_r != `IH_ECHO_LAST) begin
        echo_cnt_r <= echo_cnt_r + 5'h01;
      end
    end
  end

  // input image: module entries and live echo copies
  // a reflex wins over a bus write, as in the output image
  integer j;
  always @(posedge clk) begin
    if (in_accept && !is_echo_bind) begin
      in_mem[slot_idx] <= isl_in_data;
    end
    if (in_accept && is_echo_bind) begin
      in_mem[slot_idx] <= out_mem[isl_in_data[11:0]];
    end
    for (j = 0; j < `IH_ECHO_PAIRS; j = j + 1) begin
      if (echo_vld_r[j] && reflex_ok &&
          (echo_src_r[j] == isl_reflex_idx)) begin
        in_mem[echo_dst_r[j]] <= isl_reflex_data;
      end else if (echo_vld_r[j] && bus_out_we &&
                   (echo_src_r[j] == out_idx)) begin
        in_mem[echo_dst_r[j]] <= reg_wdata;
      end
    end
  end

  // state code: only the fifteen defined codes are taken
  // a zero or unknown code leaves the last state standing
  wire [7:0] state_in  = {4'h0, isl_state};
  wire       state_ok  = (state_in >= `IH_ST_INIT) &&
                         (state_in <= `IH_ST_LAST);
  // entry into initializing, used to clear the non-fatal bits
  wire       init_ent  = state_ok &&
                         (state_in == `IH_ST_INIT) &&
                         (state_code_r != `IH_ST_INIT);
  always @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      state_code_r <= `IH_ST_INIT;
      init_seen_r  <= 1'b0;
    end else begin
      if (state_ok) begin
        state_code_r <= state_in;
      end
      init_seen_r <= init_ent;
    end
  end

  // error status edge for the cleared indication
  always @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      err_status_d_r <= 1'b0;
    end else begin
      err_status_d_r <= isl_err_status;
    end
  end
  wire err_cleared = err_status_d_r && !isl_err_status;
  // warning needs both the counter level and the status bit
  wire warn_hit    = isl_err_status && (isl_err_count >= `IH_ERR_WARN);

  // communication error bits; fatal ones hold until reset,
  // the others clear on entry to initializing, a new event winning
  // bits 10 and 12 are the only ones a new initializing pass clears
  reg [15:8] comm_nxt;
  always @* begin
    comm_nxt = comm_err_r;
    if (init_seen_r) begin
      comm_nxt[`IH_CB_BUSOFF] = 1'b0;
      comm_nxt[`IH_CB_ERRCLR] = 1'b0;
    end
    if (isl_ev_lprx_ovr) begin
      comm_nxt[`IH_CB_LPRX] = 1'b1;
    end
    if (isl_ev_unit_ovr) begin
      comm_nxt[`IH_CB_UNIT] = 1'b1;
    end
    if (isl_ev_bus_off) begin
      comm_nxt[`IH_CB_BUSOFF] = 1'b1;
    end
    if (warn_hit) begin
      comm_nxt[`IH_CB_WARN] = 1'b1;
    end
    if (err_cleared) begin
      comm_nxt[`IH_CB_ERRCLR] = 1'b1;
    end
    if (isl_ev_lptx_ovr) begin
      comm_nxt[`IH_CB_LPTX] = 1'b1;
    end
    if (isl_ev_hprx_ovr) begin
      comm_nxt[`IH_CB_HPRX] = 1'b1;
    end
    if (isl_ev_hptx_ovr) begin
      comm_nxt[`IH_CB_HPTX] = 1'b1;
    end
  end

  // communication error register
  always @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      comm_err_r <= 8'h00;
    end else begin
      comm_err_r <= comm_nxt;
    end
  end

  // any fatal communication bit, now or arriving;
  // looking at the next value raises the halt on the same edge
  wire comm_fatal = |(comm_nxt & `IH_COMM_FATAL);

  // global error flags, sticky until reset
  // bit 0 follows the fatal communication bits, bits 1-12 the events
  reg [12:0] gerr_nxt;
  always @* begin
    gerr_nxt = gerr_r | {isl_gerr_evt, 1'b0};
    if (comm_fatal) begin
      gerr_nxt[`IH_GE_FATAL] = 1'b1;
    end
  end

  // global error register
  always @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      gerr_r <= 13'h0000;
    end else begin
      gerr_r <= gerr_nxt;
    end
  end

  // per-region read words
  wire [15:0] rd_out  = out_mem[out_idx];
  wire [15:0] rd_in   = in_mem[in_idx];
  wire [15:0] rd_comm = {comm_err_r, state_code_r};
  wire [15:0] rd_gerr = {`IH_GE_ZERO, gerr_r};
  wire        is_comm = (reg_addr == `IH_COMM_REG);
  wire        is_gerr = (reg_addr == `IH_GERR_REG);

  // read mux; unmapped and unused diagnostic words read zero
  reg [15:0] rd_nxt;
  always @* begin
    rd_nxt = 16'h0000;
    if (in_out_rng) begin
      rd_nxt = rd_out;
    end else if (in_in_rng) begin
      rd_nxt = rd_in;
    end else if (is_comm) begin
      rd_nxt = rd_comm;
    end else if (is_gerr) begin
      rd_nxt = rd_gerr;
    end
  end

  // read data registered, valid one cycle after the strobe
  // the data word stands until the next read replaces it
  always @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_nxt;
      end
    end
  end
endmodule
`default_nettype wire

// File: ih_slot_map.v
// maps a module entry onto its input block register index
`timescale 1ns/1ps
`default_nettype none
`include "ih_image_regs.vh"

module ih_slot_map (
  input  wire [1:0]  mod_type,
  input  wire [11:0] mod_base,
  input  wire [1:0]  mod_sub,
  output wire [11:0] slot_idx,
  output wire        slot_ok
);
  reg [2:0] span;

  // entries each module type owns in the input block
  always @* begin
    case (mod_type)
      `IH_TY_DI: span = `IH_N_DI; // data then status
      `IH_TY_AI: span = `IH_N_AI; // data/status per channel
      `IH_TY_DO: span = `IH_N_DO; // echo word only
      default:   span = `IH_N_AO; // status per channel, no data
    endcase
  end

  assign slot_ok  = ({1'b0, mod_sub} < span);
  assign slot_idx = mod_base + {10'h000, mod_sub};
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the island head unit register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, rst_n = 0, we = 0, rwe = 0, est = 0;
  logic [1:0] ty = 0, sub = 0;
  logic [11:0] base = 0, ridx = 0;
  logic [15:0] dat = 0, rdat = 0, rdata, addr, wd, v;
  logic [7:0] ecnt = 0;
  logic [3:0] st = 0;
  logic [5:0] ev = 0;
  logic [12:1] ge = 0;
  logic rd, wr, rv, hit, rej, halt;
  logic [15:0] expq[$];
  int errors = 0, comparisons = 0;
  always #4 clk = ~clk;
  ih_bus_master m (.clk(clk), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr), .reg_wdata(wd));
  ih_image_regs_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
    .reg_wdata(wd), .reg_rdata(rdata), .reg_rvalid(rv), .reg_hit(hit), .isl_in_we(we),
    .isl_in_type(ty), .isl_in_base(base), .isl_in_sub(sub), .isl_in_data(dat), .isl_in_reject(rej),
    .isl_reflex_we(rwe), .isl_reflex_idx(ridx), .isl_reflex_data(rdat), .isl_state(st),
    .isl_ev_lprx_ovr(ev[0]), .isl_ev_unit_ovr(ev[1]), .isl_ev_bus_off(ev[2]), .isl_ev_lptx_ovr(ev[3]),
    .isl_ev_hprx_ovr(ev[4]), .isl_ev_hptx_ovr(ev[5]), .isl_err_count(ecnt), .isl_err_status(est),
    .isl_gerr_evt(ge), .isl_comm_halt(halt));
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict;
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // decode expected from the three mapped ranges
  function automatic logic hit_exp(input logic [15:0] a);
    return (a >= 16'h9c41 && a <= 16'hac40) || (a >= 16'hb12d && a <= 16'hc14f);
  endfunction
  // note the expected word, then read; the decode is checked while the address stands
  task automatic rc(input logic [15:0] a, input logic [15:0] e);
    expq.push_back(e);
    fork
      m.op(0, a, 16'h0000);
      #1 check("hit", {15'h0, hit}, {15'h0, hit_exp(a)});
    join
    m.idle(1);
  endtask
  // one island entry with its refusal checked while held
  task automatic ent(input logic [1:0] t, input logic [11:0] b, input logic [1:0] s, input logic r);
    ty = t;
    base = b;
    sub = s;
    we = 1;
    #1 check("reject", {15'h0, rej}, {15'h0, r});
    @(negedge clk);
    we = 0;
    @(negedge clk);
  endtask
  // results are matched in order of request, sampled clear of the launching edge
  always @(negedge clk) if (rv === 1'b1) check("rdata", rdata, expq.pop_front());
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
  initial begin
    void'($urandom(3484));
    repeat (16) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    rc(16'hb12d, 16'h0001);
    m.op(1, 16'hb12d, 16'hffff);
    rc(16'hb12d, 16'h0001);
    rc(16'hb14f, 16'h0000);
    rc(16'hc150, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      v = 16'($urandom);
      m.op(1, i ? 16'hac40 : 16'h9c41, v);
      rc(i ? 16'hac40 : 16'h9c41, v);
    end
    v = 16'($urandom);
    dat = v;
    ent(0, 12'h000, 0, 0);
    dat = ~v;
    ent(0, 12'h000, 1, 0);
    ent(0, 12'h000, 2, 1);
    rc(16'hb150, v);
    rc(16'hb151, ~v);
    for (int s = 0; s < 4; s++) begin
      dat = v + 16'(s);
      ent(1, 12'h010, 2'(s), 0);
      rc(16'hb160 + 16'(s), v + 16'(s));
    end
    ent(3, 12'hffe, 1, 0);
    ent(3, 12'hffe, 2, 1);
    rc(16'hc14f, v + 16'h3);
    m.op(1, 16'h9c45, v);
    dat = 16'h0004;
    ent(2, 12'h020, 0, 0);
    ent(2, 12'h020, 1, 1);
    rc(16'hb170, v);
    m.op(1, 16'h9c45, ~v);
    rc(16'hb170, ~v);
    ridx = 12'h004;
    rdat = v ^ 16'h5a5a;
    rwe = 1;
    @(negedge clk);
    rwe = 0;
    rc(16'hb170, v ^ 16'h5a5a);
    rc(16'h9c45, v ^ 16'h5a5a);
    for (int s = 1; s < 16; s++) begin
      st = 4'(s);
      @(negedge clk);
      rc(16'hb12d, 16'(s));
    end
    ev = 6'h04;
    @(negedge clk);
    ev = 0;
    rc(16'hb12d, 16'h040f);
    st = 1;
    ecnt = 8'h5f;
    est = 1;
    repeat (2) @(negedge clk);
    est = 0;
    @(negedge clk);
    rc(16'hb12d, 16'h1001);
    for (int i = 1; i < 13; i++) begin
      ge = 12'(1) << (i - 1);
      @(negedge clk);
    end
    ge = 0;
    rc(16'hb12e, 16'h1ffe);
    check("halt", {15'h0, halt}, 16'h0000);
    ecnt = 8'h60;
    est = 1;
    repeat (3) @(negedge clk);
    check("halt", {15'h0, halt}, 16'h0001);
    for (int i = 0; i < 6; i++) if (i != 2) begin
      ev = 6'(1) << i;
      @(negedge clk);
    end
    ev = 0;
    rc(16'hb12d, 16'hfb01);
    rc(16'hb12e, 16'h1fff);
    ent(0, 12'h100, 0, 1);
    repeat (2) @(negedge clk);
    check("pending", 16'(expq.size()), 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
